// file: verilog/adcc_pkg.sv
// Package: register map, field layout and timing counts of the converter control
package adcc_pkg;
  // ==========================================================
  // Register indices (word address on the bus)
  localparam logic [2:0] IDX_MODE = 3'h0;
  localparam logic [2:0] IDX_RESULT = 3'h1;
  localparam logic [2:0] IDX_START = 3'h2;
  localparam logic [2:0] IDX_IRQ_STAT = 3'h3;
  localparam logic [2:0] IDX_IRQ_MASK = 3'h4;

  // ==========================================================
  // Field positions
  localparam int POS_SPEED = 7;
  localparam int POS_TRIG_EN = 6;
  localparam int POS_CHAN_HI = 3;
  localparam int POS_FLAG = 7;
  localparam int POS_DONE = 0;

  // ==========================================================
  // Reset and fixed read values
  localparam logic [7:0] MODE_RESET = 8'h30;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [6:0] START_RSVD = 7'h7f;
  localparam logic [3:0] CHAN_RESET = 4'h0;

  // ==========================================================
  // Conversion timing in system clock cycles
  localparam logic [5:0] PERIOD_SLOW = 6'h3e;
  localparam logic [5:0] PERIOD_FAST = 6'h1f;
  localparam logic [5:0] SAMPLE_SLOW = 6'h0e;
  localparam logic [5:0] SAMPLE_FAST = 6'h07;
  localparam logic [2:0] STEP_SLOW = 3'h6;
  localparam logic [2:0] STEP_FAST = 3'h3;
  localparam logic [7:0] SAR_FIRST = 8'h80;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcc_state_type;

  typedef struct packed {
    logic speed_select;
    logic ext_trigger_enable;
    logic [3:0] channel_sel;
  } adcc_mode_type;

  typedef struct packed {
    logic sample_hold;
    logic mux_enable;
    logic [2:0] mux_select;
    logic [7:0] dac_code;
  } adcc_afe_type;
endpackage

// file: verilog/adcc_top.sv
// Converter control: register slave, trigger, successive approximation and interrupt
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// ==========================================================
// Notes on behaviour
// - Result register is 8-bit read-only, readable any time.
// - Completion loads the approximation into result; held until next completion.
// - Reset does not touch the result register.
// - Mode register resets to 30 hex: slow, trigger off, no channel.
// - Mode bit 7 picks 62 cycles at 0 or 31 cycles at 1.
// - Mode bit 6 low ignores trigger pin; high starts on chosen edge.
// - Trigger edge polarity comes from an edge-select bit outside this block.
// - Reserved mode bits 5:4 and start bits 6:0 read one, ignore writes.
// - Channel field: 00xx none, 01xx inputs 0-3, 10xx inputs 4-7, 11xx reserved.
// - Writing start bit 7 one starts, zero stops; flag resets to zero.
// - Flag reads one while converting, self-clears with the result store.
// - Enabled trigger edge sets the flag and starts a conversion.
// - Each completion sets the done request; interrupt only when enabled.
// - Idle after completion until flag set again; each start repeats sequence.
module adcc_top
  import adcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic trigger_pin,
  input wire logic trigger_edge_polarity,
  input wire logic comp_in,
  output adcc_afe_type afe,
  output logic irq
);

  // ==========================================================
  // State
  adcc_state_type state, next_state;
  adcc_mode_type mode, next_mode;
  logic [5:0] cnt, next_cnt;
  logic [2:0] sub, next_sub;
  logic [2:0] bit_idx, next_bit_idx;
  logic [7:0] sar, next_sar;
  logic [7:0] result, next_result;
  logic trig_q, next_trig_q;
  logic irq_stat, next_irq_stat;
  logic irq_mask, next_irq_mask;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic next_irq;
  adcc_afe_type next_afe;

  // Combinational helpers
  logic acc;
  logic wr;
  logic sw_start;
  logic sw_stop;
  logic trig_edge;
  logic trig_start;
  logic done;
  logic busy;
  logic [5:0] samp_len;
  logic [2:0] step_len;
  logic [2:0] bit_low;
  logic [7:0] mode_rd;
  logic [7:0] start_rd;

  // ==========================================================
  // Bus decode: an access completes at the edge where waitrequest is low
  always_comb begin
    acc = !avs_waitrequest && (avs_read || avs_write);
    wr = acc && avs_write;
    sw_start = wr && avs_address == IDX_START && avs_writedata[POS_FLAG];
    sw_stop = wr && avs_address == IDX_START && !avs_writedata[POS_FLAG];
    busy = state != ST_IDLE;
  end

  // ==========================================================
  // Trigger edge detect; polarity bit lives in the edge-select register
  always_comb begin
    next_trig_q = trigger_pin;
    trig_edge = trigger_edge_polarity ? (trigger_pin && !trig_q) : (!trigger_pin && trig_q);
    trig_start = mode.ext_trigger_enable && trig_edge;
  end

  // ==========================================================
  // Mode register write; reserved bits never stored
  always_comb begin
    next_mode = mode;
    if (wr && avs_address == IDX_MODE) begin
      next_mode.speed_select = avs_writedata[POS_SPEED];
      next_mode.ext_trigger_enable = avs_writedata[POS_TRIG_EN];
      next_mode.channel_sel = avs_writedata[POS_CHAN_HI:0];
    end
  end

  // ==========================================================
  // Conversion sequencer
  always_comb begin
    samp_len = mode.speed_select ? SAMPLE_FAST : SAMPLE_SLOW;
    step_len = mode.speed_select ? STEP_FAST : STEP_SLOW;
    bit_low = bit_idx - 3'h1;
    next_state = state;
    next_cnt = cnt;
    next_sub = sub;
    next_bit_idx = bit_idx;
    next_sar = sar;
    next_result = result;
    done = 1'b0;
    case (state)
      ST_IDLE: begin
        // only a new start leaves idle
        if (sw_start || trig_start) begin
          next_state = ST_SAMPLE;
          next_cnt = 6'h00;
          next_sub = 3'h0;
          next_bit_idx = 3'h7;
          next_sar = SAR_FIRST;
        end
      end
      ST_SAMPLE: begin
        next_cnt = cnt + 6'h01;
        if (cnt == samp_len - 6'h01) begin
          next_state = ST_CONVERT;
          next_sub = 3'h0;
        end
      end
      ST_CONVERT: begin
        next_cnt = cnt + 6'h01;
        if (sub == step_len - 3'h1) begin
          next_sub = 3'h0;
          // Comparator low means trial code too high
          if (!comp_in) begin
            next_sar[bit_idx] = 1'b0;
          end
          if (bit_idx == 3'h0) begin
            next_result = next_sar;
            next_state = ST_IDLE;
            done = 1'b1;
          end else begin
            next_bit_idx = bit_low;
            next_sar[bit_low] = 1'b1;
          end
        end else begin
          next_sub = sub + 3'h1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // writing zero aborts without a done event
    if (sw_stop && busy) begin
      next_state = ST_IDLE;
      next_result = result;
      done = 1'b0;
    end
  end

  // ==========================================================
  // Interrupt status and mask; a set in the clearing cycle wins
  always_comb begin
    next_irq_mask = irq_mask;
    if (wr && avs_address == IDX_IRQ_MASK) begin
      next_irq_mask = avs_writedata[POS_DONE];
    end
    next_irq_stat = irq_stat;
    if (wr && avs_address == IDX_IRQ_STAT && avs_writedata[POS_DONE]) begin
      next_irq_stat = 1'b0;
    end
    if (done) begin
      next_irq_stat = 1'b1;
    end
    next_irq = next_irq_stat && next_irq_mask;
  end

  // ==========================================================
  // Read data and waitrequest: one wait cycle, then answer
  always_comb begin
    mode_rd = {mode.speed_select, mode.ext_trigger_enable, MODE_RSVD, mode.channel_sel};
    start_rd = {busy, START_RSVD};
    next_readdata = avs_readdata;
    next_waitrequest = 1'b1;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_waitrequest = 1'b0;
      case (avs_address)
        IDX_MODE: next_readdata = {24'h000000, mode_rd};
        IDX_RESULT: next_readdata = {24'h000000, result};
        IDX_START: next_readdata = {24'h000000, start_rd};
        IDX_IRQ_STAT: next_readdata = {31'h00000000, irq_stat};
        IDX_IRQ_MASK: next_readdata = {31'h00000000, irq_mask};
        default: next_readdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Analog front end controls, registered from next values
  always_comb begin
    next_afe.sample_hold = next_state == ST_SAMPLE;
    next_afe.dac_code = next_sar;
    // channel decode, 00xx and 11xx select none
    next_afe.mux_enable = next_mode.channel_sel[3] ^ next_mode.channel_sel[2];
    next_afe.mux_select = {next_mode.channel_sel[3], next_mode.channel_sel[1:0]};
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      // mode resets to slow, no trigger, no channel
      mode <= '{MODE_RESET[POS_SPEED], MODE_RESET[POS_TRIG_EN], MODE_RESET[POS_CHAN_HI:0]};
      cnt <= 6'h00;
      sub <= 3'h0;
      bit_idx <= 3'h7;
      sar <= 8'h00;
      trig_q <= 1'b0;
      irq_stat <= 1'b0;
      irq_mask <= 1'b0;
      irq <= 1'b0;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      afe <= '0;
    end else if (clk_en) begin
      state <= next_state;
      mode <= next_mode;
      cnt <= next_cnt;
      sub <= next_sub;
      bit_idx <= next_bit_idx;
      sar <= next_sar;
      trig_q <= next_trig_q;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
      afe <= next_afe;
    end
  end

  // ==========================================================
  // Result register; no reset, so its power-up value is unknown
  // untouched by reset
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      result <= next_result;
    end
  end

  // ==========================================================
  // Assertion helpers: length of the current busy run
  logic [6:0] run_len;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_len <= 7'h00;
    end else if (clk_en) begin
      run_len <= busy ? run_len + 7'h01 : 7'h00;
    end
  end

  // Result is unknown until the first completion, so its hold check waits for one
  logic result_loaded;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      result_loaded <= 1'b0;
    end else if (clk_en && done) begin
      result_loaded <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b || !clk_en);

  sequence s_idle_start;
    !busy && (sw_start || trig_start);
  endsequence

  sequence s_run_begins;
    ##1 busy && afe.sample_hold && afe.dac_code == SAR_FIRST;
  endsequence

  // Period length ties completion to the speed bit
  a_conv_period_len: assert property (
    done |-> run_len == (mode.speed_select ? 7'h1e : 7'h3d))
    else $error("conversion period wrong for speed setting");

  // Start from idle raises flag and sampling
  a_start_sets_flag: assert property (
    s_idle_start |-> s_run_begins)
    else $error("start did not begin a conversion");

  // Trigger gating in both directions
  a_trig_ignored_off: assert property (
    !busy && trig_edge && !mode.ext_trigger_enable && !sw_start |=> !busy)
    else $error("trigger started while disabled");

  a_trig_starts_run: assert property (
    !busy && trig_edge && mode.ext_trigger_enable |=> busy ##1 busy)
    else $error("enabled trigger edge did not start conversion");

  // Stop write aborts quietly
  a_stop_no_done: assert property (
    busy && sw_stop |=> !busy && $stable(irq_stat))
    else $error("stop failed or raised done");

  // Completion updates land together; a clear in that cycle loses to the set
  a_done_one_cycle: assert property (
    done |=> !busy && irq_stat && result == $past(next_sar))
    else $error("result, flag and request not updated together");

  a_result_holds: assert property (
    result_loaded && !done |=> $stable(result))
    else $error("result changed outside completion");

  // Idle stays idle without a start
  a_idle_until_start: assert property (
    !busy && !sw_start && !trig_start |=> !busy)
    else $error("conversion began without a start");

  // Interrupt output level
  a_irq_follows_mask: assert property (
    irq == (irq_stat && irq_mask))
    else $error("interrupt output not following status and mask");

  a_irq_low_masked: assert property (
    !irq_mask && !(wr && avs_address == IDX_IRQ_MASK) |=> !irq)
    else $error("interrupt raised while masked");

  // Bus handshake and readback
  a_mode_rsvd_ones: assert property (
    avs_read && avs_waitrequest && avs_address == IDX_MODE |=> avs_readdata[5:4] == MODE_RSVD)
    else $error("reserved mode bits not read as one");

  a_flag_readback: assert property (
    avs_read && avs_waitrequest && avs_address == IDX_START |=>
      avs_readdata[7:0] == {$past(busy), START_RSVD})
    else $error("start register readback wrong");

  a_bus_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  // Channel decode, both the off codes and the input codes
  a_chan_none: assert property (
    mode.channel_sel[3] == mode.channel_sel[2] && $stable(mode) |-> !afe.mux_enable)
    else $error("channel enabled for none or reserved code");

  // Codes 01xx pick inputs 0 to 3, codes 10xx inputs 4 to 7
  a_mux_decode: assert property (
    mode.channel_sel[3] != mode.channel_sel[2] |-> afe.mux_enable &&
      afe.mux_select == {mode.channel_sel[3], mode.channel_sel[1:0]})
    else $error("channel code selected the wrong input");

endmodule

// file: dv/adcc_analog_model.sv
// Partner model: analog input multiplexer and comparator beside the converter control
`timescale 1ns/100ps
module adcc_analog_model
  import adcc_pkg::*;
#(
  parameter logic [63:0] LEVELS = 64'h3ce15a960fa5c37e
)
(
  input wire adcc_afe_type afe,
  output logic comp_in
);
  // ==========================================================
  // Comparator
  logic [7:0] level;

  // One fixed level per input; a deselected mux sees ground, so the trial always fails
  always_comb begin
    level = LEVELS[{afe.mux_select, 3'h0} +: 8];
    comp_in = afe.mux_enable && (level >= afe.dac_code);
  end
endmodule

// file: dv/adc_conversion_control_test.sv
// Testbench: register accesses, conversions, trigger and interrupt of the converter control
`timescale 1ns/100ps
module adc_conversion_control_test
  import adcc_pkg::*;
;
  // ==========================================================
  // Signals
  localparam logic [63:0] LEVELS = 64'h3ce15a960fa5c37e;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic trigger_pin = 1'b0;
  logic trigger_edge_polarity = 1'b1;
  logic comp_in;
  adcc_afe_type afe;
  logic irq;
  logic [31:0] rd;
  logic [7:0] exp;
  int n_errors = 0;
  int samples_checked = 0;
  int n;

  // Clock at 25 ns
  always #12.5 clk_sys = ~clk_sys;

  // ==========================================================
  // Design and far side
  adcc_top dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trigger_pin(trigger_pin), .trigger_edge_polarity(trigger_edge_polarity),
    .comp_in(comp_in), .afe(afe), .irq(irq)
  );
  adcc_analog_model #(.LEVELS(LEVELS)) model_u (.afe(afe), .comp_in(comp_in));

  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Request held until waitrequest is sampled low; starts after an edge, so no double drive
  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) n_errors++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] want, input string what);
    bus(1'b0, a, 8'h00);
    chk(what, rd, {24'h0, want});
  endtask

  // Counts edges after the start until irq is settled high
  task automatic wait_irq(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end while (irq !== 1'b1 && cnt < 200);
    if (cnt >= 200) n_errors++;
  endtask

  task automatic idle_wait();
    repeat (70) @(posedge clk_sys);
  endtask

  task automatic summarize;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog, far above the roughly 1500 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    summarize;
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk(IDX_MODE, 8'h30, "mode reset");
    rchk(IDX_START, 8'h7f, "start reset");
    rchk(IDX_IRQ_STAT, 8'h00, "status reset");
    rchk(3'h5, 8'h00, "unmapped read");
    bus(1'b1, IDX_MODE, 8'h0f);
    rchk(IDX_MODE, 8'h3f, "mode reserved bits");
    bus(1'b1, IDX_IRQ_MASK, 8'h01);
    // Slow conversion on input 1, period measured at irq
    bus(1'b1, IDX_MODE, 8'h05);
    bus(1'b1, IDX_START, 8'hff);
    wait_irq(n);
    chk("slow period", n, 32'(PERIOD_SLOW));
    rchk(IDX_START, 8'h7f, "flag cleared");
    rchk(IDX_IRQ_STAT, 8'h01, "done request");
    // result read only once the flag reads zero
    rchk(IDX_RESULT, LEVELS[15:8], "result input 1");
    bus(1'b1, IDX_RESULT, 8'h00);
    rchk(IDX_RESULT, LEVELS[15:8], "result read only");
    bus(1'b1, IDX_IRQ_STAT, 8'h01);
    rchk(IDX_IRQ_STAT, 8'h00, "status cleared");
    chk("irq cleared", irq, 32'h0);
    // Clock enable low freezes a running conversion, which then resumes
    bus(1'b1, IDX_START, 8'h80);
    clk_en <= 1'b0;
    repeat (70) @(posedge clk_sys);
    chk("frozen irq", irq, 32'h0);
    clk_en <= 1'b1;
    wait_irq(n);
    chk("frozen period", n, 32'(PERIOD_SLOW));
    bus(1'b1, IDX_IRQ_STAT, 8'h01);
    // software picks speed; the model accepts either one
    // channel written only while idle; every code, fast speed
    for (int c = 0; c < 16; c++) begin
      exp = (c[3] ^ c[2]) ? LEVELS[{c[3], c[1:0], 3'h0} +: 8] : 8'h00;
      bus(1'b1, IDX_MODE, 8'h80 | 8'(c));
      rchk(IDX_MODE, 8'hb0 | 8'(c), "mode channel");
      bus(1'b1, IDX_START, 8'h80);
      wait_irq(n);
      chk("fast period", n, 32'(PERIOD_FAST));
      rchk(IDX_RESULT, exp, "channel result");
      bus(1'b1, IDX_IRQ_STAT, 8'h01);
    end
    // Stop in mid-conversion
    bus(1'b1, IDX_MODE, 8'h04);
    bus(1'b1, IDX_START, 8'h80);
    rchk(IDX_START, 8'hff, "flag busy");
    // stop before the mode is touched again
    bus(1'b1, IDX_START, 8'h00);
    rchk(IDX_START, 8'h7f, "flag stopped");
    idle_wait();
    rchk(IDX_IRQ_STAT, 8'h00, "no done on stop");
    // Completion with the interrupt masked
    bus(1'b1, IDX_IRQ_MASK, 8'h00);
    bus(1'b1, IDX_START, 8'h80);
    idle_wait();
    chk("irq masked", irq, 32'h0);
    rchk(IDX_IRQ_STAT, 8'h01, "masked done");
    rchk(IDX_RESULT, LEVELS[7:0], "result input 0");
    bus(1'b1, IDX_IRQ_STAT, 8'h01);
    bus(1'b1, IDX_IRQ_MASK, 8'h01);
    // Trigger pin with the trigger disabled
    @(posedge clk_sys);
    trigger_pin <= 1'b1;
    idle_wait();
    rchk(IDX_IRQ_STAT, 8'h00, "trigger disabled");
    // Trigger on rising edges: a falling edge must not start
    bus(1'b1, IDX_MODE, 8'h45);
    @(posedge clk_sys);
    trigger_pin <= 1'b0;
    idle_wait();
    rchk(IDX_IRQ_STAT, 8'h00, "wrong edge");
    @(posedge clk_sys);
    trigger_pin <= 1'b1;
    wait_irq(n);
    chk("rising trigger", n, 32'(PERIOD_SLOW) + 32'h1);
    rchk(IDX_RESULT, LEVELS[15:8], "trigger result");
    bus(1'b1, IDX_IRQ_STAT, 8'h01);
    // Falling edges selected, fast speed on input 2
    bus(1'b1, IDX_MODE, 8'hc6);
    @(posedge clk_sys);
    trigger_edge_polarity <= 1'b0;
    @(posedge clk_sys);
    trigger_pin <= 1'b0;
    wait_irq(n);
    rchk(IDX_IRQ_STAT, 8'h01, "falling trigger");
    rchk(IDX_RESULT, LEVELS[23:16], "falling result");
    // Second reset leaves the result alone
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk(IDX_RESULT, LEVELS[23:16], "result kept");
    rchk(IDX_MODE, 8'h30, "mode after reset");
    summarize;
  end
endmodule
